/* File: src/osc_ctrl_map.svh */
// Register offsets, field positions, reset values and timing counts of the oscillator block
// Summary of operation
// (RULE1) Drive mode 0 low current, 1 high current
// (RULE2) Drive mode frozen while pins selected and enabled
// (RULE3) Drive mode writable when either pin deselected
// (RULE4) Crystal enable clears, later sets stable flag
// (RULE5) Bit 0 enables high-speed crystal oscillator
// (RULE6) Unimplemented upper bits always read zero
// (RULE7) Speed-up bit 2: fast start or low power
// (RULE8) Speed-up frozen while low crystal is system clock
// (RULE9) Low enable clears, later sets stable flag
// (RULE10) Bit 0 enables low-speed crystal oscillator
// (RULE11) PLL input select: 0 is 12MHz, 1 is 6MHz
// (RULE12) Halve 12MHz crystal, then multiply by eight
// (RULE13) RC source selected clears PLL input select
// (RULE14) Output select: raw, 6, 12, 16MHz, reserved
// (RULE15) PLL enable clears, later sets stable flag
// (RULE16) Bit 0 enables PLL, enabled after reset
// (RULE17) Clock switch needs four plus partial periods
// (RULE18) High source select: 0 RC, 1 crystal
// (RULE19) Low source select: 0 RC, 1 crystal
// (RULE20) System select 111 picks the low subclock
// (RULE21) Stable flags come from restartable counters
// (RULE22) Software keeps reserved top bits at zero
`ifndef OSC_CTRL_MAP_SVH
`define OSC_CTRL_MAP_SVH

// Byte offsets of the word-aligned registers
`define OFS_HS_CTRL 5'h00
`define OFS_LS_CTRL 5'h04
`define OFS_PLL_CTRL 5'h08
`define OFS_SYS_CFG 5'h0C
`define OFS_PIN_CFG 5'h10

// Field positions shared by both crystal registers
`define BIT_ENABLE 0
`define BIT_STABLE 1
`define BIT_MODE 2

// Field positions of the PLL register
`define BIT_PLL_OSEL_LO 2
`define BIT_PLL_ISEL 5
`define BIT_PLL_RSVD 7

// Field positions of the system clock configuration register
`define BIT_LFSS 2
`define BIT_HFSS 3
`define BIT_SCS_LO 5

// Field positions of the pin configuration and status register
`define BIT_PIN_IN 0
`define BIT_PIN_OUT 1
`define BIT_SW_BUSY 4

// Reset values of the low byte of each register
`define RST_HS_CTRL 8'h00
`define RST_LS_CTRL 8'h00
`define RST_PLL_CTRL 8'h01
`define RST_SYS_CFG 8'h00
`define RST_PIN_CFG 8'h00

// Codes and constants
`define SCS_SUBCLOCK 3'h7
`define PLL_MULT 4'h8
`define SW_BASE_CYCLES 4

`endif

/* File: src/osc_ctrl_pkg.sv */
// Types shared by the oscillator and PLL control block
package osc_ctrl_pkg;

	// Clock controls handed to the analogue oscillators and the PLL
	typedef struct packed {
		logic hs_crystal_enable;
		logic hs_drive_mode;
		logic ls_crystal_enable;
		logic ls_speedup;
		logic pll_enable;
		logic pll_input_select;
		logic [2:0] pll_output_select;
		logic pll_ref_div2;
		logic [3:0] pll_mult;
		logic fh_from_pll;
		logic [1:0] pll_freq_code;
		logic osc_in_pin_func;
		logic osc_out_pin_func;
	} clk_ctrl_t;

	// System clock source configuration
	typedef struct packed {
		logic [2:0] system_clock_select;
		logic high_freq_source_select;
		logic low_freq_source_select;
	} sys_clk_cfg_t;

	// Stable flags and switch status
	typedef struct packed {
		logic hs_stable_flag;
		logic ls_stable_flag;
		logic pll_stable_flag;
		logic switch_busy;
	} clk_status_t;

	// Clock switch timer, Gray coded along the path
	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_BASE = 2'b01,
		SW_TAIL = 2'b11
	} switch_state_t;

endpackage

/* File: src/stab_counter.sv */
// Stabilisation counter that drives one oscillator stable flag
`timescale 1ns/100ps
module stab_counter
	import osc_ctrl_pkg::*;
#(
	parameter int unsigned LEN = 1024
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic enable,
	output logic stable
);

	localparam int CW = $clog2(LEN + 1);

	// Cycles counted since enable rose
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	// Stable flag
	logic flag_q;
	logic flag_d;

	// Next count and flag
	always_comb
	begin
		cnt_d = cnt_q;
		flag_d = flag_q;
		// (RULE21) restart on disable
		if (!enable)
		begin
			cnt_d = '0;
			flag_d = 1'b0;
		end
		else if (!flag_q)
		begin
			if (cnt_q == CW'(LEN - 1))
				flag_d = 1'b1;
			else
				cnt_d = cnt_q + CW'(1);
		end
	end

	// Count registers
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q <= '0;
			flag_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			flag_q <= flag_d;
		end
	end

	assign stable = flag_q;

endmodule

/* File: src/clock_switch_timer.sv */
// Timer that marks a clock switch in progress after an output select change
`timescale 1ns/100ps
`include "osc_ctrl_map.svh"
module clock_switch_timer
	import osc_ctrl_pkg::*;
#(
	parameter int unsigned TAIL_CYCLES = 2
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic change,
	output logic busy
);

	localparam int CW = 8;

	// Switch state and its cycle count
	switch_state_t state_q;
	switch_state_t state_d;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// Next state: fixed system periods, then a margin for the edges
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			SW_IDLE:
			begin
				cnt_d = '0;
			end
			SW_BASE:
			begin
				// (RULE17) four system periods
				if (cnt_q == CW'(`SW_BASE_CYCLES - 1))
				begin
					state_d = SW_TAIL;
					cnt_d = '0;
				end
				else
					cnt_d = cnt_q + CW'(1);
			end
			SW_TAIL:
			begin
				// (RULE17) partial clock margin
				if (cnt_q >= CW'(TAIL_CYCLES - 1))
					state_d = SW_IDLE;
				else
					cnt_d = cnt_q + CW'(1);
			end
			default:
			begin
				state_d = SW_IDLE;
				cnt_d = '0;
			end
		endcase
		// A new change restarts the whole wait
		if (change)
		begin
			state_d = SW_BASE;
			cnt_d = '0;
		end
	end

	// State registers
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= SW_IDLE;
			cnt_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	assign busy = (state_q != SW_IDLE);

endmodule

/* File: src/oscillator_pll_control.sv */
// Oscillator and PLL control registers with their Avalon-MM slave
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps
`include "osc_ctrl_map.svh"
module oscillator_pll_control
	import osc_ctrl_pkg::*;
#(
	// Stabilisation lengths in system clock cycles
	parameter int unsigned HS_STAB_CYCLES = 1024,
	parameter int unsigned LS_STAB_CYCLES = 1024,
	parameter int unsigned PLL_STAB_CYCLES = 1024,
	// Margin after the fixed part of a clock switch
	parameter int unsigned SWITCH_TAIL_CYCLES = 2
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output clk_ctrl_t ctrl,
	output sys_clk_cfg_t sys_cfg,
	output clk_status_t status
);

	// Bus slave state

	// Set in the cycle after a request is seen, releasing waitrequest
	logic ack_q;
	logic ack_d;
	// Read data, loaded at the same edge that drops waitrequest
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// Register state

	// High-speed crystal drive mode and enable
	logic hs_drive_mode_q;
	logic hs_drive_mode_d;
	logic hs_crystal_enable_q;
	logic hs_crystal_enable_d;
	// Low-speed crystal speed-up and enable
	logic ls_speedup_q;
	logic ls_speedup_d;
	logic ls_crystal_enable_q;
	logic ls_crystal_enable_d;
	// PLL fields
	logic reserved_top_bit_q;
	logic reserved_top_bit_d;
	logic pll_input_select_q;
	logic pll_input_select_d;
	logic [2:0] pll_output_select_q;
	logic [2:0] pll_output_select_d;
	logic pll_enable_q;
	logic pll_enable_d;
	// System clock configuration
	logic [2:0] system_clock_select_q;
	logic [2:0] system_clock_select_d;
	logic high_freq_source_select_q;
	logic high_freq_source_select_d;
	logic low_freq_source_select_q;
	logic low_freq_source_select_d;
	// Oscillator pin functions chosen by pin sharing
	logic osc_in_pin_func_q;
	logic osc_in_pin_func_d;
	logic osc_out_pin_func_q;
	logic osc_out_pin_func_d;

	// Decoded strobes and status

	// A request is live on the bus
	logic req;
	// Write committed at the edge where waitrequest is low
	logic wr_commit;
	// Low byte lane written
	logic wr_lane0;
	// Low byte of the write data
	logic [7:0] wbyte;
	// Drive mode locked against writes
	logic hs_mode_locked;
	// Speed-up locked against writes
	logic ls_speedup_locked;
	// Pulse when the output select really changes
	logic osel_change;
	// Stable flags from the counters
	logic hs_stable;
	logic ls_stable;
	logic pll_stable;
	// Clock switch in progress
	logic sw_busy;

	// Address selects the word at a given offset
	function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
		hit = (addr[4:2] == ofs[4:2]);
	endfunction

	// Map a byte of register contents into the read word
	function automatic logic [31:0] word(input logic [7:0] b);
		word = {24'h00_0000, b};
	endfunction

	// Bus handshake

	// One wait cycle per request; the master holds it until waitrequest is low
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_q;
	assign wr_commit = avs_write & ack_q;
	assign wr_lane0 = wr_commit & avs_byteenable[0];
	assign wbyte = avs_writedata[7:0];

	// Next handshake state and read data
	always_comb
	begin
		ack_d = req & ~ack_q;
		rdata_d = rdata_q;
		if (avs_read && !ack_q)
		begin
			// (RULE6) upper bits read zero
			case (avs_address[4:2])
				3'(`OFS_HS_CTRL >> 2):
					rdata_d = word({5'h00, hs_drive_mode_q, hs_stable, hs_crystal_enable_q});
				3'(`OFS_LS_CTRL >> 2):
					rdata_d = word({5'h00, ls_speedup_q, ls_stable, ls_crystal_enable_q});
				3'(`OFS_PLL_CTRL >> 2):
					rdata_d = word({reserved_top_bit_q, 1'b0, pll_input_select_q,
						pll_output_select_q, pll_stable, pll_enable_q});
				3'(`OFS_SYS_CFG >> 2):
					rdata_d = word({system_clock_select_q, 1'b0, high_freq_source_select_q,
						low_freq_source_select_q, 2'b00});
				3'(`OFS_PIN_CFG >> 2):
					rdata_d = word({3'h0, sw_busy, 2'b00, osc_out_pin_func_q,
						osc_in_pin_func_q});
				// Unmapped words read as zero
				default:
					rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Handshake registers
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata = rdata_q;

	// Write locks

	// (RULE2) both pins selected and enabled
	// (RULE3) either pin off frees it
	assign hs_mode_locked = osc_in_pin_func_q & osc_out_pin_func_q & hs_crystal_enable_q;

	// (RULE8) low crystal drives system
	assign ls_speedup_locked = (system_clock_select_q == `SCS_SUBCLOCK)
		& low_freq_source_select_q;

	// Crystal register updates
	always_comb
	begin
		hs_drive_mode_d = hs_drive_mode_q;
		hs_crystal_enable_d = hs_crystal_enable_q;
		ls_speedup_d = ls_speedup_q;
		ls_crystal_enable_d = ls_crystal_enable_q;
		if (wr_lane0 && hit(avs_address, `OFS_HS_CTRL))
		begin
			// (RULE1) drive current select
			if (!hs_mode_locked)
				hs_drive_mode_d = wbyte[`BIT_MODE];
			// (RULE5) crystal enable bit
			hs_crystal_enable_d = wbyte[`BIT_ENABLE];
		end
		if (wr_lane0 && hit(avs_address, `OFS_LS_CTRL))
		begin
			// (RULE7) speed-up select
			if (!ls_speedup_locked)
				ls_speedup_d = wbyte[`BIT_MODE];
			// (RULE10) crystal enable bit
			ls_crystal_enable_d = wbyte[`BIT_ENABLE];
		end
	end

	// Crystal registers, cleared at power-on
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hs_drive_mode_q <= 1'(`RST_HS_CTRL >> `BIT_MODE);
			hs_crystal_enable_q <= 1'(`RST_HS_CTRL >> `BIT_ENABLE);
			ls_speedup_q <= 1'(`RST_LS_CTRL >> `BIT_MODE);
			ls_crystal_enable_q <= 1'(`RST_LS_CTRL >> `BIT_ENABLE);
		end
		else
		begin
			hs_drive_mode_q <= hs_drive_mode_d;
			hs_crystal_enable_q <= hs_crystal_enable_d;
			ls_speedup_q <= ls_speedup_d;
			ls_crystal_enable_q <= ls_crystal_enable_d;
		end
	end

	// PLL and clock configuration updates
	always_comb
	begin
		reserved_top_bit_d = reserved_top_bit_q;
		pll_input_select_d = pll_input_select_q;
		pll_output_select_d = pll_output_select_q;
		pll_enable_d = pll_enable_q;
		system_clock_select_d = system_clock_select_q;
		high_freq_source_select_d = high_freq_source_select_q;
		low_freq_source_select_d = low_freq_source_select_q;
		osc_in_pin_func_d = osc_in_pin_func_q;
		osc_out_pin_func_d = osc_out_pin_func_q;
		if (wr_lane0 && hit(avs_address, `OFS_PLL_CTRL))
		begin
			// Reserved bit is stored as written; software keeps it low
			reserved_top_bit_d = wbyte[`BIT_PLL_RSVD];
			// (RULE11) reference frequency select
			pll_input_select_d = wbyte[`BIT_PLL_ISEL];
			pll_output_select_d = wbyte[`BIT_PLL_OSEL_LO +: 3];
			// (RULE16) PLL enable bit
			pll_enable_d = wbyte[`BIT_ENABLE];
		end
		if (wr_lane0 && hit(avs_address, `OFS_SYS_CFG))
		begin
			// (RULE20) system source code
			system_clock_select_d = wbyte[`BIT_SCS_LO +: 3];
			// (RULE18) high source select
			high_freq_source_select_d = wbyte[`BIT_HFSS];
			// (RULE19) low source select
			low_freq_source_select_d = wbyte[`BIT_LFSS];
		end
		if (wr_lane0 && hit(avs_address, `OFS_PIN_CFG))
		begin
			osc_in_pin_func_d = wbyte[`BIT_PIN_IN];
			osc_out_pin_func_d = wbyte[`BIT_PIN_OUT];
		end
		// (RULE13) RC source forces zero
		// Applied after the write so a same-cycle write cannot sneak a 1 in
		if (!high_freq_source_select_d)
			pll_input_select_d = 1'b0;
	end

	// PLL and configuration registers; the PLL leaves reset enabled
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reserved_top_bit_q <= 1'(`RST_PLL_CTRL >> `BIT_PLL_RSVD);
			pll_input_select_q <= 1'(`RST_PLL_CTRL >> `BIT_PLL_ISEL);
			pll_output_select_q <= 3'(`RST_PLL_CTRL >> `BIT_PLL_OSEL_LO);
			pll_enable_q <= 1'(`RST_PLL_CTRL >> `BIT_ENABLE);
			system_clock_select_q <= 3'(`RST_SYS_CFG >> `BIT_SCS_LO);
			high_freq_source_select_q <= 1'(`RST_SYS_CFG >> `BIT_HFSS);
			low_freq_source_select_q <= 1'(`RST_SYS_CFG >> `BIT_LFSS);
			osc_in_pin_func_q <= 1'(`RST_PIN_CFG >> `BIT_PIN_IN);
			osc_out_pin_func_q <= 1'(`RST_PIN_CFG >> `BIT_PIN_OUT);
		end
		else
		begin
			reserved_top_bit_q <= reserved_top_bit_d;
			pll_input_select_q <= pll_input_select_d;
			pll_output_select_q <= pll_output_select_d;
			pll_enable_q <= pll_enable_d;
			system_clock_select_q <= system_clock_select_d;
			high_freq_source_select_q <= high_freq_source_select_d;
			low_freq_source_select_q <= low_freq_source_select_d;
			osc_in_pin_func_q <= osc_in_pin_func_d;
			osc_out_pin_func_q <= osc_out_pin_func_d;
		end
	end

	// Stable flags

	// (RULE4) high crystal stable flag
	stab_counter #(
		.LEN(HS_STAB_CYCLES)
	) u_hs_stab (
		.clock(clock),
		.rst_b(rst_b),
		.enable(hs_crystal_enable_q),
		.stable(hs_stable)
	);

	// (RULE9) low crystal stable flag
	stab_counter #(
		.LEN(LS_STAB_CYCLES)
	) u_ls_stab (
		.clock(clock),
		.rst_b(rst_b),
		.enable(ls_crystal_enable_q),
		.stable(ls_stable)
	);

	// (RULE15) PLL stable flag
	stab_counter #(
		.LEN(PLL_STAB_CYCLES)
	) u_pll_stab (
		.clock(clock),
		.rst_b(rst_b),
		.enable(pll_enable_q),
		.stable(pll_stable)
	);

	// Clock switch tracking

	// Only a real change of the select starts the wait, not a rewrite
	assign osel_change = (pll_output_select_d != pll_output_select_q);

	// (RULE17) switch busy window
	clock_switch_timer #(
		.TAIL_CYCLES(SWITCH_TAIL_CYCLES)
	) u_switch (
		.clock(clock),
		.rst_b(rst_b),
		.change(osel_change),
		.busy(sw_busy)
	);

	// Outputs to the oscillators and PLL

	// Drive the control struct straight from the registers
	always_comb
	begin
		ctrl.hs_crystal_enable = hs_crystal_enable_q;
		ctrl.hs_drive_mode = hs_drive_mode_q;
		ctrl.ls_crystal_enable = ls_crystal_enable_q;
		ctrl.ls_speedup = ls_speedup_q;
		ctrl.pll_enable = pll_enable_q;
		ctrl.pll_input_select = pll_input_select_q;
		ctrl.pll_output_select = pll_output_select_q;
		// (RULE12) halve 12MHz crystal
		ctrl.pll_ref_div2 = high_freq_source_select_q & ~pll_input_select_q;
		ctrl.pll_mult = `PLL_MULT;
		// (RULE14) 0xx raw, 1xx PLL
		// Reserved code 111 falls back to the raw oscillator as a safe clock
		ctrl.fh_from_pll = pll_output_select_q[2] & ~(&pll_output_select_q[1:0]);
		ctrl.pll_freq_code = pll_output_select_q[1:0];
		ctrl.osc_in_pin_func = osc_in_pin_func_q;
		ctrl.osc_out_pin_func = osc_out_pin_func_q;
	end

	// System configuration and status views
	always_comb
	begin
		sys_cfg.system_clock_select = system_clock_select_q;
		sys_cfg.high_freq_source_select = high_freq_source_select_q;
		sys_cfg.low_freq_source_select = low_freq_source_select_q;
		status.hs_stable_flag = hs_stable;
		status.ls_stable_flag = ls_stable;
		status.pll_stable_flag = pll_stable;
		status.switch_busy = sw_busy;
	end

endmodule

/* File: verif/crystal_model.sv */
// Behavioural crystal that sits on the oscillator pins
`timescale 1ns/100ps
module crystal_model
#(
	// Nominal crystal frequency in MHz
	parameter int unsigned FREQ_MHZ = 12
)
(
	input wire logic clock,
	input wire logic enable,
	input wire logic drive_mode,
	output logic osc_wave,
	output logic drive_ok
);
	assign drive_ok = drive_mode == (FREQ_MHZ > 10);

	// Swings only while enabled; a stopped crystal rests low, not on its last level
	always_ff @(posedge clock)
		osc_wave <= enable && !osc_wave;
endmodule

/* File: verif/oscillator_pll_control_sva.sv */
// Port-level checks of the oscillator and PLL control block
`timescale 1ns/100ps
module oscillator_pll_control_sva
	import osc_ctrl_pkg::*;
#(
	parameter int unsigned HS_STAB_CYCLES = 1024,
	parameter int unsigned LS_STAB_CYCLES = 1024,
	parameter int unsigned PLL_STAB_CYCLES = 1024,
	parameter int unsigned SWITCH_TAIL_CYCLES = 2
)
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire clk_ctrl_t ctrl,
	input wire sys_clk_cfg_t sys_cfg,
	input wire clk_status_t status
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	// Cycles each enable has been high, saturating at its length
	int unsigned hs_age_q, hs_age_d, ls_age_q, ls_age_d, pll_age_q, pll_age_d;
	// Switch cycles still owed, and the previous output select
	int unsigned sw_q, sw_d;
	logic [2:0] osel_q, osel_d;
	logic chg;

	function automatic int unsigned age_next(logic en, int unsigned age, int unsigned len);
		return en ? ((age < len) ? age + 1 : age) : 0;
	endfunction

	// Next values of the reference counters
	always_comb
	begin
		hs_age_d = age_next(ctrl.hs_crystal_enable, hs_age_q, HS_STAB_CYCLES);
		ls_age_d = age_next(ctrl.ls_crystal_enable, ls_age_q, LS_STAB_CYCLES);
		pll_age_d = age_next(ctrl.pll_enable, pll_age_q, PLL_STAB_CYCLES);
		osel_d = ctrl.pll_output_select;
		chg = ctrl.pll_output_select != osel_q;
		// A change restarts the count, since a new switch supersedes the old
		sw_d = chg ? 3 + SWITCH_TAIL_CYCLES : ((sw_q > 0) ? sw_q - 1 : 0);
	end

	// Register the reference counters
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hs_age_q <= 0;
			ls_age_q <= 0;
			pll_age_q <= 0;
			sw_q <= 0;
			osel_q <= 3'h0;
		end
		else
		begin
			hs_age_q <= hs_age_d;
			ls_age_q <= ls_age_d;
			pll_age_q <= pll_age_d;
			sw_q <= sw_d;
			osel_q <= osel_d;
		end
	end

	a_hs_stable_time: assert property (
		status.hs_stable_flag == (hs_age_q == HS_STAB_CYCLES))
		else $error("high-speed stable flag timing wrong");
	a_ls_stable_time: assert property (
		status.ls_stable_flag == (ls_age_q == LS_STAB_CYCLES))
		else $error("low-speed stable flag timing wrong");
	a_pll_stable_time: assert property (
		status.pll_stable_flag == (pll_age_q == PLL_STAB_CYCLES))
		else $error("PLL stable flag timing wrong");
	a_switch_busy_len: assert property (
		status.switch_busy == (chg || sw_q != 0))
		else $error("switch busy length wrong");
	a_mode_write_lock: assert property (
		ctrl.osc_in_pin_func && ctrl.osc_out_pin_func && ctrl.hs_crystal_enable
		|=> $stable(ctrl.hs_drive_mode))
		else $error("drive mode changed while locked");
	a_speedup_lock: assert property (
		sys_cfg.system_clock_select == 3'h7 && sys_cfg.low_freq_source_select
		|=> $stable(ctrl.ls_speedup))
		else $error("speed-up changed while low crystal runs system");
	a_isel_auto_clear: assert property (
		!sys_cfg.high_freq_source_select |-> !ctrl.pll_input_select)
		else $error("PLL input select set with RC source");
	a_pll_ref_path: assert property (
		ctrl.pll_ref_div2 == (sys_cfg.high_freq_source_select && !ctrl.pll_input_select)
		&& ctrl.pll_mult == 4'h8)
		else $error("PLL reference path wrong");
	a_out_route: assert property (
		ctrl.fh_from_pll == (ctrl.pll_output_select[2] && ctrl.pll_output_select[1:0] != 2'h3)
		&& ctrl.pll_freq_code == ctrl.pll_output_select[1:0])
		else $error("PLL output routing wrong");
	a_unimpl_zero: assert property (
		avs_read && !avs_waitrequest && avs_address[4:3] == 2'h0 |-> avs_readdata[7:3] == 5'h00)
		else $error("unimplemented crystal bits read nonzero");
endmodule

/* File: verif/test_oscillator_pll_control.sv */
// Self-checking bench for the oscillator and PLL control block
`timescale 1ns/100ps
`include "osc_ctrl_map.svh"
module test_oscillator_pll_control
	import osc_ctrl_pkg::*;
;
	localparam int STAB = 4;
	localparam int TAIL = 2;
	logic clock, rst_b, avs_read, avs_write, avs_waitrequest, drive_ok;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic [7:0] pll_s, sys_s, d;
	clk_ctrl_t ctrl;
	sys_clk_cfg_t sys_cfg;
	clk_status_t status;
	int num_errors = 0, n_tests = 0, seed = 85552, n, k;

	// Short stabilisation and tail keep the run brief
	oscillator_pll_control #(.HS_STAB_CYCLES(STAB), .LS_STAB_CYCLES(STAB),
		.PLL_STAB_CYCLES(STAB), .SWITCH_TAIL_CYCLES(TAIL)) uut (.clock(clock), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ctrl(ctrl),
		.sys_cfg(sys_cfg), .status(status));
	// A 12 MHz crystal on the oscillator pins
	crystal_model #(.FREQ_MHZ(12)) xtal (.clock(clock), .enable(ctrl.hs_crystal_enable),
		.drive_mode(ctrl.hs_drive_mode), .osc_wave(), .drive_ok(drive_ok));

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
			num_errors++;
		end
	endtask

	task automatic test_done();
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] wd,
		input logic [3:0] be);
		int i;
		@(posedge clock);
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= be;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clock);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		if (i == 20)
		begin
			num_errors++;
			test_done();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		bus(1'b0, a, {24'h00_0000, v}, 4'hF);
		// The write lands at the edge just taken; look only once it has settled
		@(negedge clock);
	endtask

	task automatic rdchk(input string name, input logic [4:0] a, input logic [31:0] exp,
		input logic [31:0] mask);
		bus(1'b1, a, 32'h0000_0000, 4'hF);
		check(name, q & mask, exp);
	endtask

	// Cycles a status bit stays at one level, bounded
	task automatic count(input int idx, input logic lvl, output int c);
		c = 0;
		repeat (40)
		begin
			@(posedge clock);
			if (status[3 - idx] !== lvl)
				break;
			c++;
		end
	endtask

	// Expected PLL readback, stable flag masked off
	function automatic logic [7:0] exp_pll(logic [7:0] v, logic hfss);
		return {v[7], 1'b0, v[5] & hfss, v[4:2], 2'b00} | {7'h00, v[0]};
	endfunction

	initial
	begin
		rst_b = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		check("pll_enable", ctrl.pll_enable, 1'b1);
		count(2, 1'b0, n);
		check("pll_flag_time", n, STAB);
		rdchk("hs_reset", `OFS_HS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
		rdchk("ls_reset", `OFS_LS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
		rdchk("pll_reset", `OFS_PLL_CTRL, 32'h0000_0003, 32'hFFFF_FFFF);
		wr(5'h14, 8'hFF);
		rdchk("unmapped", 5'h14, 32'h0000_0000, 32'hFFFF_FFFF);
		// Drive mode and enable together while both pins serve the crystal
		wr(`OFS_PIN_CFG, 8'h03);
		wr(`OFS_HS_CTRL, 8'h05);
		count(0, 1'b0, n);
		check("hs_flag_time", n, STAB);
		check("drive_ok", drive_ok, 1'b1);
		wr(`OFS_HS_CTRL, 8'h01);
		rdchk("hs_locked", `OFS_HS_CTRL, 32'h0000_0007, 32'hFFFF_FFFF);
		wr(`OFS_PIN_CFG, 8'h01);
		wr(`OFS_HS_CTRL, 8'h01);
		rdchk("hs_unlocked", `OFS_HS_CTRL, 32'h0000_0003, 32'hFFFF_FFFF);
		wr(`OFS_HS_CTRL, 8'h00);
		rdchk("hs_off", `OFS_HS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
		wr(`OFS_LS_CTRL, 8'h05);
		count(1, 1'b0, n);
		check("ls_flag_time", n, STAB);
		check("ls_speedup", ctrl.ls_speedup, 1'b1);
		wr(`OFS_SYS_CFG, 8'hE4);
		wr(`OFS_LS_CTRL, 8'h01);
		rdchk("ls_locked", `OFS_LS_CTRL, 32'h0000_0007, 32'hFFFF_FFFF);
		wr(`OFS_SYS_CFG, 8'h00);
		wr(`OFS_LS_CTRL, 8'h01);
		rdchk("ls_unlocked", `OFS_LS_CTRL, 32'h0000_0003, 32'hFFFF_FFFF);
		wr(`OFS_PLL_CTRL, 8'h21);
		check("isel_rc", ctrl.pll_input_select, 1'b0);
		wr(`OFS_SYS_CFG, 8'h08);
		wr(`OFS_PLL_CTRL, 8'h21);
		check("isel_6m", ctrl.pll_input_select, 1'b1);
		check("div2_6m", ctrl.pll_ref_div2, 1'b0);
		wr(`OFS_PLL_CTRL, 8'h01);
		check("div2_12m", ctrl.pll_ref_div2, 1'b1);
		// Every output select code, each after the first a change from the one before
		for (k = 0; k < 8; k++)
		begin
			wr(`OFS_PLL_CTRL, {3'h0, k[2:0], 2'b01});
			count(3, 1'b1, n);
			check("switch_len", n, (k == 0) ? 0 : 4 + TAIL);
			check("fh_pll", ctrl.fh_from_pll, k >= 4 && k < 7);
			rdchk("pin_idle", `OFS_PIN_CFG, 32'h0000_0001, 32'hFFFF_FFFF);
		end
		// Random writes with random lanes, each read back
		pll_s = 8'h1D;
		sys_s = 8'h08;
		repeat (30)
		begin
			k = $random(seed);
			// top two bits, reserved and unimplemented in the PLL register, written as zero
			d = k[15:8] & 8'h3F;
			bus(1'b0, (k[1:0] == 2'h0) ? 5'h18 : (k[0] ? `OFS_PLL_CTRL : `OFS_SYS_CFG),
				{24'h00_0000, d}, k[7:4]);
			if (k[4] && k[1:0] != 2'h0 && k[0])
				pll_s = exp_pll(d, sys_s[3]);
			if (k[4] && k[1:0] == 2'h2)
			begin
				sys_s = d & 8'hEC;
				pll_s[5] = pll_s[5] & sys_s[3];
			end
			rdchk("rand_pll", `OFS_PLL_CTRL, {24'h00_0000, pll_s}, 32'hFFFF_FFFD);
			rdchk("rand_sys", `OFS_SYS_CFG, {24'h00_0000, sys_s}, 32'hFFFF_FFFF);
			rdchk("rand_gap", 5'h18, 32'h0000_0000, 32'hFFFF_FFFF);
		end
		test_done();
	end
endmodule

bind oscillator_pll_control oscillator_pll_control_sva #(.HS_STAB_CYCLES(HS_STAB_CYCLES),
	.LS_STAB_CYCLES(LS_STAB_CYCLES), .PLL_STAB_CYCLES(PLL_STAB_CYCLES),
	.SWITCH_TAIL_CYCLES(SWITCH_TAIL_CYCLES)) chk (.clock(clock), .rst_b(rst_b),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ctrl(ctrl),
	.sys_cfg(sys_cfg), .status(status));
